// ===== rtl/fucs_pkg.sv
package fucs_pkg;
   // timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned BIT_RATE_BPS    = 2_400_000;
   // half bit period, rounded down so the bit rate is never below 2.4 Mbps
   localparam int unsigned HALF_BIT_CYC_RAW = CLK_HZ / (2 * BIT_RATE_BPS);
   localparam int unsigned HALF_BIT_CYC    = (HALF_BIT_CYC_RAW < 1) ? 1 : HALF_BIT_CYC_RAW;
   localparam int unsigned DATA_BITS       = 8;
   // commands
   localparam logic [7:0]  CMD_SESSION_BEGIN = 8'h10;
   localparam logic [7:0]  CMD_ERASE         = 8'h11;
   localparam logic [7:0]  CMD_PROGRAM       = 8'h12;
   // erase block selector range and padding
   localparam logic [7:0]  SEL_MAX         = 8'h25;
   localparam logic [7:0]  PAD_BYTE        = 8'hff;
   localparam int unsigned UNIT_BYTES      = 256;
   localparam int unsigned SIZE_BYTES      = 4;
   // default example session
   localparam logic [7:0]  DEF_SELECTOR    = 8'h07;
   localparam logic [31:0] DEF_PROG_SIZE   = 32'h0000_2000;
   localparam logic [3:0]  IND_SUCCESS     = 4'hf;
   localparam logic [3:0]  IND_ERROR       = 4'h5;
   localparam logic [3:0]  IND_OFF         = 4'h0;
   // erase block sizes: selectors below this are 16 KiB blocks, the rest 4 KiB
   localparam logic [7:0]  SEL_FIRST_SMALL = 8'h1e;
   localparam logic [31:0] BIG_BLOCK_BYTES = 32'h0000_4000;
   localparam logic [31:0] SMALL_BLOCK_BYTES = 32'h0000_1000;

   typedef enum logic [3:0] {
      FUCS_IDLE, FUCS_SEND, FUCS_WAIT, FUCS_DONE, FUCS_FAIL
   } fucs_state_e;

   typedef enum logic [2:0] {
      FUCS_PH_BEGIN, FUCS_PH_ERASE, FUCS_PH_SEL, FUCS_PH_PROG, FUCS_PH_SIZE, FUCS_PH_DATA, FUCS_PH_END
   } fucs_phase_e;
endpackage : fucs_pkg

// ===== rtl/fucs_sender.sv
// Function
// - every character is 8 data bits, lsb first, at 2.4 Mbps; 20-cycle half bits at 100 MHz give 2.5 Mbps here.
// - this master makes and drives the serial bit clock; the slave never drives it.
// - the next step starts only after a rising edge of the handshake line.
// - commands are 10h session begin, 11h erase, 12h program.
// - the erase request names exactly one erase block of the 38 blocks.
// - after erasure the master sends a four byte size then the programming data.
// - the session starts only on a trigger input event.
// - on success the four indicator outputs show the success pattern.
// - multi-byte values follow the byte order strap, 0 little, 1 big endian.
// - the selector byte follows the erase command and lies in 00h to 25h.
// - the size is nonzero and no larger than the selected block.
// - data goes in 256-byte units, a short last unit padded with ffh.
`timescale 1ns/100ps
module fucs_sender #(
   parameter logic [7:0]  ERASE_SELECTOR = fucs_pkg::DEF_SELECTOR,
   parameter logic [31:0] PROG_SIZE      = fucs_pkg::DEF_PROG_SIZE
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       trigger_input_i,
   input  wire logic       handshake_input_i,
   input  wire logic       byte_order_strap_i,
   input  wire logic [7:0] prog_data_i,
   output logic            prog_data_req_o,
   output logic            serial_bit_clock_pin_o,
   output logic            serial_bit_clock_pin_oe_o,
   output logic            serial_tx_pin_o,
   output logic            serial_tx_pin_oe_o,
   output logic [3:0]      indicator_o,
   output logic            busy_o
);

   typedef struct packed {
      fucs_pkg::fucs_state_e state;
      fucs_pkg::fucs_phase_e phase;
      logic [7:0]            shift;
      logic [3:0]            bit_cnt;
      logic [7:0]            div_cnt;
      logic                  sck;
      logic                  tx;
      logic                  oe;
      logic [1:0]            size_idx;
      logic [31:0]           byte_cnt;
      logic                  big_endian;
      logic                  trig_d;
      logic                  hs_d;
      logic                  data_req;
      logic [3:0]            ind;
      logic                  busy;
   } fucs_regs_s;

   fucs_regs_s r_reg;
   fucs_regs_s r_next;

   logic [31:0] blk_size;
   logic [7:0]  size_byte;
   logic [1:0]  lane;
   logic [31:0] padded_total;
   logic        params_ok;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      blk_size  = (ERASE_SELECTOR < fucs_pkg::SEL_FIRST_SMALL) ? fucs_pkg::BIG_BLOCK_BYTES
                                                              : fucs_pkg::SMALL_BLOCK_BYTES;
      params_ok = (ERASE_SELECTOR <= fucs_pkg::SEL_MAX) && (PROG_SIZE != 32'h0000_0000)
                  && (PROG_SIZE <= blk_size);
      // round size up to whole units
      padded_total = (PROG_SIZE + 32'(fucs_pkg::UNIT_BYTES - 1)) & ~32'(fucs_pkg::UNIT_BYTES - 1);
      lane      = r_reg.big_endian ? 2'(fucs_pkg::SIZE_BYTES - 1) - r_reg.size_idx : r_reg.size_idx;
      size_byte = PROG_SIZE[8*lane +: 8];
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_next          = r_reg;
      r_next.trig_d   = trigger_input_i;
      r_next.hs_d     = handshake_input_i;
      r_next.data_req = 1'b0;
      case (r_reg.state)
         fucs_pkg::FUCS_IDLE: begin
            r_next.oe  = 1'b0;
            r_next.sck = 1'b1;
            r_next.tx  = 1'b1;
            if (trigger_input_i && !r_reg.trig_d) begin
               r_next.big_endian = byte_order_strap_i;
               r_next.ind        = fucs_pkg::IND_OFF;
               if (params_ok) begin
                  r_next.phase   = fucs_pkg::FUCS_PH_BEGIN;
                  r_next.shift   = fucs_pkg::CMD_SESSION_BEGIN;
                  r_next.bit_cnt = 4'h0;
                  r_next.div_cnt = 8'h00;
                  // a finished session leaves the last size lane behind; restart from the first
                  r_next.size_idx = 2'h0;
                  r_next.oe      = 1'b1;
                  r_next.state   = fucs_pkg::FUCS_SEND;
               end else begin
                  r_next.state = fucs_pkg::FUCS_FAIL;
               end
            end
         end
         fucs_pkg::FUCS_SEND: begin
            // tx changes on the falling edge, slave samples on the rising edge
            if (r_reg.div_cnt == 8'(fucs_pkg::HALF_BIT_CYC - 1)) begin
               r_next.div_cnt = 8'h00;
               if (r_reg.sck) begin
                  if (r_reg.bit_cnt == 4'(fucs_pkg::DATA_BITS)) begin
                     r_next.bit_cnt = 4'h0;
                     r_next.tx      = 1'b1;
                     // one byte done; pick what follows
                     case (r_reg.phase)
                        fucs_pkg::FUCS_PH_BEGIN, fucs_pkg::FUCS_PH_SEL, fucs_pkg::FUCS_PH_DATA:
                           r_next.state = fucs_pkg::FUCS_WAIT;
                        fucs_pkg::FUCS_PH_ERASE: begin
                           r_next.phase = fucs_pkg::FUCS_PH_SEL;
                           r_next.shift = ERASE_SELECTOR;
                        end
                        fucs_pkg::FUCS_PH_PROG: begin
                           r_next.phase    = fucs_pkg::FUCS_PH_SIZE;
                           r_next.size_idx = 2'h0;
                           r_next.shift    = size_byte;
                        end
                        fucs_pkg::FUCS_PH_SIZE: begin
                           if (r_reg.size_idx == 2'(fucs_pkg::SIZE_BYTES - 1)) begin
                              r_next.phase    = fucs_pkg::FUCS_PH_DATA;
                              r_next.byte_cnt = 32'h0;
                              r_next.state    = fucs_pkg::FUCS_WAIT;
                           end else begin
                              r_next.size_idx = r_reg.size_idx + 2'h1;
                           end
                        end
                        default: r_next.state = fucs_pkg::FUCS_FAIL;
                     endcase
                  end else begin
                     r_next.sck   = 1'b0;
                     r_next.tx    = r_reg.shift[0];
                     r_next.shift = {1'b1, r_reg.shift[7:1]};
                  end
               end else begin
                  r_next.sck     = 1'b1;
                  r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               end
            end else begin
               r_next.div_cnt = r_reg.div_cnt + 8'h01;
            end
            // size bytes load one at a time, in strap order
            if (r_reg.phase == fucs_pkg::FUCS_PH_SIZE && r_reg.bit_cnt == 4'h0 && r_reg.div_cnt == 8'h00
                && r_reg.sck && r_reg.size_idx != 2'h0) begin
               r_next.shift = size_byte;
            end
         end
         fucs_pkg::FUCS_WAIT: begin
            // data bytes stream without handshake inside a unit; the slave is busy only between units
            if (r_reg.phase == fucs_pkg::FUCS_PH_DATA && r_reg.byte_cnt != 32'h0
                && r_reg.byte_cnt[7:0] != 8'h00) begin
               r_next.shift    = (r_reg.byte_cnt < PROG_SIZE) ? prog_data_i : fucs_pkg::PAD_BYTE;
               r_next.data_req = r_reg.byte_cnt < PROG_SIZE;
               r_next.byte_cnt = r_reg.byte_cnt + 32'h1;
               r_next.state    = fucs_pkg::FUCS_SEND;
            end else if (handshake_input_i && !r_reg.hs_d) begin
               r_next.state = fucs_pkg::FUCS_SEND;
               case (r_reg.phase)
                  fucs_pkg::FUCS_PH_BEGIN: begin
                     r_next.phase = fucs_pkg::FUCS_PH_ERASE;
                     r_next.shift = fucs_pkg::CMD_ERASE;
                  end
                  fucs_pkg::FUCS_PH_SEL: begin
                     r_next.phase = fucs_pkg::FUCS_PH_PROG;
                     r_next.shift = fucs_pkg::CMD_PROGRAM;
                  end
                  fucs_pkg::FUCS_PH_DATA: begin
                     if (r_reg.byte_cnt == padded_total) begin
                        r_next.oe    = 1'b0;
                        r_next.state = fucs_pkg::FUCS_DONE;
                     end else begin
                        r_next.shift    = prog_data_i;
                        r_next.data_req = 1'b1;
                        r_next.byte_cnt = r_reg.byte_cnt + 32'h1;
                     end
                  end
                  default: r_next.state = fucs_pkg::FUCS_FAIL;
               endcase
            end
         end
         fucs_pkg::FUCS_DONE: begin
            // success shows only once the sequencer is idle again
            r_next.ind   = fucs_pkg::IND_SUCCESS;
            r_next.state = fucs_pkg::FUCS_IDLE;
         end
         fucs_pkg::FUCS_FAIL: begin
            r_next.ind   = fucs_pkg::IND_ERROR;
            r_next.oe    = 1'b0;
            r_next.state = fucs_pkg::FUCS_IDLE;
         end
         default: r_next.state = fucs_pkg::FUCS_IDLE;
      endcase
      r_next.busy = (r_next.state != fucs_pkg::FUCS_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg       <= '0;
         r_reg.state <= fucs_pkg::FUCS_IDLE;
         r_reg.sck   <= 1'b1;
         r_reg.tx    <= 1'b1;
         r_reg.shift <= fucs_pkg::PAD_BYTE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign serial_bit_clock_pin_o    = r_reg.sck;
   assign serial_bit_clock_pin_oe_o = r_reg.oe;
   assign serial_tx_pin_o           = r_reg.tx;
   assign serial_tx_pin_oe_o        = r_reg.oe;
   assign indicator_o               = r_reg.ind;
   assign prog_data_req_o           = r_reg.data_req;
   assign busy_o                    = r_reg.busy;

endmodule : fucs_sender

// ===== verification/fucs_sender_chk.sv
`timescale 1ns/100ps
module fucs_sender_chk (
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       trigger_input_i,
   input wire logic       handshake_input_i,
   input wire logic       prog_data_req_o,
   input wire logic       serial_bit_clock_pin_o,
   input wire logic       serial_bit_clock_pin_oe_o,
   input wire logic       serial_tx_pin_o,
   input wire logic       serial_tx_pin_oe_o,
   input wire logic [3:0] indicator_o,
   input wire logic       busy_o
);
   localparam int HALF = 20;
   int   low_run;
   int   nbit;
   logic armed;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   function automatic logic step_end(int n);
      return n == 1 || n == 3 || n == 8 || (n > 8 && (n - 8) % 256 == 0);
   endfunction : step_end
   // counters and the armed flag only; a session per reset is assumed, so nbit never clears between sessions
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_run <= 0;
         nbit    <= 0;
         armed   <= 1'b0;
      end else begin
         low_run <= serial_bit_clock_pin_o ? 0 : low_run + 1;
         if ($rose(serial_bit_clock_pin_o)) nbit <= nbit + 1;
         if ($rose(handshake_input_i)) armed <= 1'b1;
         else if ($fell(serial_bit_clock_pin_o)) armed <= 1'b0;
      end
   end
   sequence s_step_begin;
      $fell(serial_bit_clock_pin_o) && nbit % 8 == 0 && step_end(nbit / 8);
   endsequence
   sequence s_bit_sample;
      $rose(serial_bit_clock_pin_o) && serial_bit_clock_pin_oe_o;
   endsequence
   AST_HS_GATE: assert property (s_step_begin |-> armed)
      else $error("step began without handshake rise");
   AST_HALF_BIT: assert property (s_bit_sample |-> low_run == HALF)
      else $error("bit clock low phase wrong length");
   AST_TX_SETUP: assert property (s_bit_sample |-> $stable(serial_tx_pin_o))
      else $error("data moved at sampling edge");
   AST_IDLE_HIGH: assert property (!serial_bit_clock_pin_oe_o |-> serial_bit_clock_pin_o && serial_tx_pin_o)
      else $error("idle lines not high");
   AST_OE_PAIR: assert property (serial_bit_clock_pin_oe_o == serial_tx_pin_oe_o)
      else $error("enables differ");
   AST_WHOLE_CHARS: assert property ($fell(serial_bit_clock_pin_oe_o) |-> nbit % 8 == 0)
      else $error("link released mid character");
   AST_START: assert property ($rose(serial_bit_clock_pin_oe_o) |-> $past(trigger_input_i) || $past(trigger_input_i, 2))
      else $error("session without trigger");
   AST_REQ_PULSE: assert property (prog_data_req_o |=> !prog_data_req_o ##1 1'b1)
      else $error("data request longer than one cycle");
   AST_REQ_AFTER_HDR: assert property (prog_data_req_o |-> nbit >= 64 && serial_bit_clock_pin_oe_o)
      else $error("data taken before size");
   AST_SUCCESS: assert property (indicator_o == fucs_pkg::IND_SUCCESS |-> !busy_o && !serial_bit_clock_pin_oe_o)
      else $error("success shown while active");
   AST_ERR_SILENT: assert property (indicator_o == fucs_pkg::IND_ERROR |-> !serial_bit_clock_pin_oe_o)
      else $error("error with link driven");
endmodule : fucs_sender_chk
bind fucs_sender fucs_sender_chk chk (.*);

// ===== verification/fucs_sender_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module fucs_sender_test;
   typedef logic [7:0] fucs_bq_t[$];
   localparam logic [7:0]  SEL [2]  = '{8'h25, 8'h00};
   localparam logic [31:0] SZ [2]   = '{32'h0000_0003, 32'h0000_0001};
   localparam logic [7:0]  BSEL [3] = '{8'h26, 8'h00, 8'h1e};
   localparam logic [31:0] BSZ [3]  = '{32'h0000_0001, 32'h0000_0000, 32'h0000_1001};
   logic       core_clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       trig = 1'b0;
   logic [7:0] pdat [2];
   logic       req [2], sck [2], sck_oe [2], tx [2], tx_oe [2], hs [2], busy [2], vld [2];
   logic [7:0] rbyte [2];
   logic [3:0] ind [2], bind_o [3];
   logic       boe [3], bseen [3];
   fucs_bq_t   rx [2], dq [2];
   int         n_errors = 0, samples_checked = 0, cyc = 0;
   int         seed = 32'h9591ac18;
   initial forever #5 core_clk_i = ~core_clk_i;
   for (genvar g = 0; g < 2; g++) begin : gen_ok
      fucs_sender #(.ERASE_SELECTOR(SEL[g]), .PROG_SIZE(SZ[g])) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
         .trigger_input_i(trig), .handshake_input_i(hs[g]), .byte_order_strap_i(1'(g)), .prog_data_i(pdat[g]),
         .prog_data_req_o(req[g]), .serial_bit_clock_pin_o(sck[g]), .serial_bit_clock_pin_oe_o(sck_oe[g]),
         .serial_tx_pin_o(tx[g]), .serial_tx_pin_oe_o(tx_oe[g]), .indicator_o(ind[g]), .busy_o(busy[g]));
      // one fast and one slow far side
      fucs_slave_model #(.DELAY(g ? 300 : 50)) slv (.core_clk_i(core_clk_i), .sck_i(sck[g]), .sck_oe_i(sck_oe[g]),
         .tx_i(tx[g]), .tx_oe_i(tx_oe[g]), .handshake_o(hs[g]), .byte_vld_o(vld[g]), .byte_o(rbyte[g]));
      always @(posedge core_clk_i) if (vld[g]) rx[g].push_back(rbyte[g]);
   end
   for (genvar b = 0; b < 3; b++) begin : gen_bad
      fucs_sender #(.ERASE_SELECTOR(BSEL[b]), .PROG_SIZE(BSZ[b])) dut_bad (.core_clk_i(core_clk_i),
         .rst_n_i(rst_n_i), .trigger_input_i(trig), .handshake_input_i(1'b1), .byte_order_strap_i(1'b0),
         .prog_data_i(8'h00), .prog_data_req_o(), .serial_bit_clock_pin_o(), .serial_bit_clock_pin_oe_o(boe[b]),
         .serial_tx_pin_o(), .serial_tx_pin_oe_o(), .indicator_o(bind_o[b]), .busy_o());
      initial bseen[b] = 1'b0;
      always @(posedge core_clk_i) if (boe[b] === 1'b1) bseen[b] <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   function automatic fucs_bq_t exp_stream(int g);
      fucs_bq_t q = '{8'h10, 8'h11, SEL[g], 8'h12};
      for (int i = 0; i < 4; i++) q.push_back(SZ[g][8 * (g ? 3 - i : i) +: 8]);
      for (int i = 0; i < 256; i++) q.push_back(i < SZ[g] ? dq[g][i] : 8'hff);
      return q;
   endfunction : exp_stream
   function automatic logic [3:0] exp_ind(logic [7:0] s, logic [31:0] z);
      logic [31:0] blk = (s < 8'h1e) ? 32'h0000_4000 : 32'h0000_1000;
      return (s > 8'h25 || z == 0 || z > blk) ? 4'h5 : 4'hf;
   endfunction : exp_ind
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      for (int g = 0; g < 2; g++) if (req[g] === 1'b1) begin
         dq[g].push_back(pdat[g]);
         pdat[g] <= 8'($random(seed));
      end
      // both sessions run side by side, about 91k cycles with the slow far side
      if (cyc == 98000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      fucs_bq_t q;
      pdat[0] = 8'($random(seed));
      pdat[1] = 8'($random(seed));
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      trig <= 1'b1;
      repeat (2000) @(posedge core_clk_i);
      trig <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      trig <= 1'b1; // ignored while busy
      repeat (10) @(posedge core_clk_i);
      trig <= 1'b0;
      while (busy[0] !== 1'b0 || busy[1] !== 1'b0) @(posedge core_clk_i);
      repeat (2) @(posedge core_clk_i);
      for (int g = 0; g < 2; g++) begin
         `CHK(dq[g].size(), int'(SZ[g]))
         q = exp_stream(g);
         `CHK(rx[g].size(), q.size())
         for (int i = 0; i < q.size() && i < rx[g].size(); i++) `CHK(rx[g][i], q[i])
         `CHK(ind[g], exp_ind(SEL[g], SZ[g]))
         $display("session %0d done", g);
      end
      for (int b = 0; b < 3; b++) begin
         `CHK(bind_o[b], exp_ind(BSEL[b], BSZ[b]))
         `CHK(bseen[b], 1'b0)
      end
      $display("parameter refusal done");
      report_and_stop();
   end
endmodule : fucs_sender_test

// ===== verification/fucs_slave_model.sv
`timescale 1ns/100ps
module fucs_slave_model #(
   parameter int DELAY = 50
) (
   input  wire logic       core_clk_i,
   input  wire logic       sck_i,
   input  wire logic       sck_oe_i,
   input  wire logic       tx_i,
   input  wire logic       tx_oe_i,
   output logic            handshake_o,
   output logic            byte_vld_o,
   output logic [7:0]      byte_o
);
   logic [7:0] sh = 8'h00;
   int         nbit = 0;
   int         wait_cnt = 0;
   logic       sck_d = 1'b1;
   // both lines have pull-ups, so a released line reads high
   wire logic  sck_w = sck_oe_i ? sck_i : 1'b1;
   wire logic  tx_w = tx_oe_i ? tx_i : 1'b1;
   initial handshake_o = 1'b1;
   initial byte_vld_o = 1'b0;
   always @(posedge core_clk_i) begin
      sck_d <= sck_w;
      byte_vld_o <= 1'b0;
      if (wait_cnt == 1) handshake_o <= 1'b1;
      if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      if (sck_w && !sck_d) begin
         sh = {tx_w, sh[7:1]};
         nbit = nbit + 1;
         if (nbit % 8 == 0) begin
            byte_vld_o <= 1'b1;
            byte_o <= sh;
            // busy only after a whole step, as the master waits only there
            if (nbit == 8 || nbit == 24 || nbit == 64 || (nbit > 64 && (nbit - 64) % 2048 == 0)) begin
               handshake_o <= 1'b0;
               wait_cnt <= DELAY;
            end
         end
      end
   end
endmodule : fucs_slave_model
